// ==== common/fcpd_pkg.sv ====
// Package: constants, opcodes and carrier types of the command decoder
package fcpd_pkg;
  // APB register byte offsets
  localparam logic [7:0] ADDR_CMD_DATA = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_PARAM0 = 8'h08;
  localparam logic [7:0] ADDR_PARAM1 = 8'h0C;
  localparam logic [7:0] ADDR_CONFIG = 8'h10;
  // Opcodes, low five bits of the first command byte
  localparam logic [4:0] OP_READ = 5'h06;
  localparam logic [4:0] OP_WRITE = 5'h05;
  localparam logic [4:0] OP_VERIFY = 5'h16;
  localparam logic [4:0] OP_SPECIFY = 5'h03;
  localparam logic [4:0] OP_SENSE_INT = 5'h08;
  localparam logic [4:0] OP_CONFIGURE = 5'h13;
  localparam logic [4:0] OP_PERP = 5'h12;
  localparam logic [4:0] OP_LOCK = 5'h14;
  localparam logic [4:0] OP_SEEK = 5'h0F;
  // Parameter byte counts
  localparam logic [3:0] NP_XFER = 4'h8;
  localparam logic [3:0] NP_SPECIFY = 4'h2;
  localparam logic [3:0] NP_CONFIGURE = 4'h3;
  localparam logic [3:0] NP_PERP = 4'h1;
  localparam logic [3:0] NP_SEEK = 4'h2;
  // Bit positions inside command and parameter bytes
  localparam int MT_BIT = 7;
  localparam int MFM_BIT = 6;
  localparam int REL_BIT = 7;
  localparam int DIR_BIT = 6;
  localparam int EC_BIT = 7;
  localparam int LOCK_BIT = 7;
  localparam int OW_BIT = 7;
  localparam int PERP_D0_BIT = 2;
  localparam int PERP_GAP_BIT = 1;
  localparam int HEAD_BIT = 2;
  localparam int EIS_BIT = 6;
  localparam int FIFO_DISABLE_LOW_BIT = 5;
  localparam int POLL_BIT = 4;
  // Result and reset values
  localparam logic [7:0] ST0_INVALID = 8'h80;
  localparam logic [7:0] ST0_SEEK_END = 8'h20;
  localparam logic FIFO_DIS_RST = 1'b1;
  localparam logic [3:0] FIFO_THRESHOLD_RST = 4'h0;
  localparam logic [7:0] PRECOMP_START_TRACK_RST = 8'h00;
  localparam logic [6:0] HLT_RST = 7'h01;
  localparam logic [3:0] HUT_RST = 4'h1;
  localparam logic [15:0] SECTOR_BASE_BYTES = 16'h0080;
  localparam logic [7:0] FIRST_SECTOR = 8'h01;
  // Head timing unit
  localparam int CLK_PERIOD_NS = 20;
  localparam int HEAD_UNIT_NS = 1000;
  localparam int HEAD_UNIT_CYC_I = (HEAD_UNIT_NS + CLK_PERIOD_NS - 1)
    / CLK_PERIOD_NS;
  localparam logic [5:0] HEAD_UNIT_CYC = 6'(HEAD_UNIT_CYC_I);

  typedef enum logic [1:0] {
    ST_CMD = 2'b00,
    ST_PARAM = 2'b01,
    ST_EXEC = 2'b11,
    ST_RESULT = 2'b10
  } fcpd_phase_type;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } fcpd_apb_req_type;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } fcpd_apb_rsp_type;

  typedef struct packed {
    logic [1:0] drive_select_bits;
    logic [1:0] drive_onehot;
    logic head_select;
    logic [7:0] cylinder;
    logic [7:0] id_head;
    logic [7:0] sector;
    logic [2:0] size_code;
    logic [7:0] last_sector_number;
    logic [7:0] intersector_gap_length;
    logic [7:0] short_sector_length;
    logic [7:0] sectors_per_track;
  } fcpd_params_type;
endpackage

// ==== design/fcpd_decoder.sv ====
// Floppy command acceptance and parameter decoder with APB slave
// Functional notes
// - Check first command byte for valid opcode; invalid raises interrupt.
// - Sense interrupt status after invalid opcode answers invalid command.
// - Cylinder address is an eight-bit value, 0 to 255.
// - Perpendicular drive flag one marks that drive perpendicular.
// - Relative seek direction 0 steps out, 1 steps in.
// - Size code zero: 128-byte sector, short length sets bytes moved.
// - Excess sector bytes dropped on reads, zero-filled on writes.
// - CRC covers the full physical sector.
// - Verify count enable turns short length into sectors per track.
// - FIFO enable bit active low; one disables and is default.
// - Implied seek bit requests seek before read or write.
// - Last sector number ends processing on the track.
// - Perpendicular gap parameter alters gap 2 length.
// - Gap length parameter sets gap 3 size.
// - Head select picks disk side 0 or 1.
// - Wait head-load interval before read or write.
// - Unload head after head-unload interval past execution end.
// - Lock keeps FIFO and precompensation settings across soft reset.
// - Density bit one selects MFM, zero selects FM.
// - Multi-track continues at first sector under head 1.
//
// Implementation choices: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module fcpd_decoder
  import fcpd_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire fcpd_apb_req_type apb_req,
  output fcpd_apb_rsp_type apb_rsp,
  input wire logic soft_reset_dor,
  input wire logic soft_reset_dsr,
  input wire logic disk_byte,
  input wire logic exec_done,
  output fcpd_params_type params,
  output logic int_req,
  output logic head_load,
  output logic head_ready,
  output logic host_pass,
  output logic zero_fill,
  output logic crc_byte,
  output logic implied_seek_req,
  output logic step_dir,
  output logic rel_seek,
  output logic fifo_enabled,
  output logic [3:0] fifo_threshold,
  output logic [7:0] precomp_start_track,
  output logic mfm_mode,
  output logic perp_gap2_alter,
  output logic [7:0] gap3_length,
  output logic [1:0] perp_drive_flags
);
  typedef struct packed {
    fcpd_phase_type phase;
    logic [7:0] opcode;
    logic [3:0] byte_idx;
    logic [3:0] need;
    fcpd_params_type prm;
    logic [6:0] head_load_delay;
    logic [3:0] head_unload_delay;
    logic fifo_disable_low;
    logic [3:0] fifo_threshold;
    logic [7:0] precomp_start_track;
    logic implied_seek_enable;
    logic polling_disable;
    logic lock;
    logic [1:0] perp_flags;
    logic perp_gap;
    logic int_pending;
    logic int_invalid;
    logic res_idx;
    logic step_dir;
    logic rel_seek;
    logic count_enable;
    logic multi_track_flag;
    logic mfm;
    logic head_loaded;
    logic loading;
    logic unloading;
    logic [7:0] dly_cnt;
    logic [5:0] unit_cnt;
    logic [15:0] byte_pos;
    logic pslverr;
    logic [31:0] prdata;
  } fcpd_regs_type;

  localparam fcpd_regs_type REGS_RST = '{
    phase: ST_CMD,
    head_load_delay: HLT_RST,
    head_unload_delay: HUT_RST,
    fifo_disable_low: FIFO_DIS_RST,
    fifo_threshold: FIFO_THRESHOLD_RST,
    precomp_start_track: PRECOMP_START_TRACK_RST,
    default: '0
  };

  fcpd_regs_type r_q;
  fcpd_regs_type r_d;

  logic acc_wr;
  logic acc_rd;
  logic setup;
  logic mapped;
  logic [4:0] op_lo;
  logic first_valid;
  logic [3:0] first_need;
  logic is_xfer;
  logic is_seek;
  logic is_read;
  logic is_write;
  logic [15:0] phys_len;
  logic [15:0] host_len;
  logic [7:0] result_byte;
  logic [31:0] rd_mux;
  logic soft_rst;
  logic [7:0] wb;

  assign setup = apb_req.psel && !apb_req.penable;
  assign acc_wr = apb_req.psel && apb_req.penable && apb_req.pwrite;
  assign acc_rd = apb_req.psel && apb_req.penable && !apb_req.pwrite;
  assign wb = apb_req.pwdata[7:0];
  assign mapped = apb_req.paddr == ADDR_CMD_DATA ||
    apb_req.paddr == ADDR_STATUS || apb_req.paddr == ADDR_PARAM0 ||
    apb_req.paddr == ADDR_PARAM1 || apb_req.paddr == ADDR_CONFIG;
  assign soft_rst = soft_reset_dor || soft_reset_dsr;

  // Opcode check on the incoming first byte
  assign op_lo = wb[4:0];
  always_comb begin
    first_valid = 1'b1;
    first_need = 4'h0;
    case (op_lo)
      OP_READ, OP_WRITE: first_need = NP_XFER;
      OP_VERIFY: first_need = NP_XFER;
      OP_SPECIFY: first_need = NP_SPECIFY;
      OP_CONFIGURE: first_need = NP_CONFIGURE;
      OP_PERP: first_need = NP_PERP;
      OP_SEEK: first_need = NP_SEEK;
      OP_SENSE_INT, OP_LOCK: first_need = 4'h0;
      default: first_valid = 1'b0;
    endcase
  end

  assign is_read = r_q.opcode[4:0] == OP_READ;
  assign is_write = r_q.opcode[4:0] == OP_WRITE;
  assign is_xfer = is_read || is_write || r_q.opcode[4:0] == OP_VERIFY;
  assign is_seek = r_q.opcode[4:0] == OP_SEEK;

  // Physical sector size doubles per size code step
  assign phys_len = SECTOR_BASE_BYTES << r_q.prm.size_code;
  // Verify with count enable keeps full sectors
  assign host_len = (r_q.prm.size_code == 3'h0 && !r_q.count_enable) ?
    {8'h00, r_q.prm.short_sector_length} : phys_len;

  assign result_byte = (r_q.res_idx == 1'b0) ?
    (r_q.int_invalid ? ST0_INVALID :
    (ST0_SEEK_END | {5'h00, r_q.prm.head_select,
    r_q.prm.drive_select_bits})) : r_q.prm.cylinder;

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (apb_req.paddr)
      ADDR_CMD_DATA: rd_mux = {24'h000000,
        (r_q.phase == ST_RESULT) ? result_byte : 8'h00};
      ADDR_STATUS: rd_mux = {24'h000000,
        r_q.phase != ST_EXEC, r_q.phase == ST_RESULT, 1'b0,
        r_q.phase != ST_CMD, r_q.loading, r_q.head_loaded,
        r_q.int_invalid, r_q.int_pending};
      ADDR_PARAM0: rd_mux = {r_q.prm.cylinder, r_q.prm.sector,
        r_q.prm.last_sector_number, 5'h00, r_q.prm.size_code};
      ADDR_PARAM1: rd_mux = {r_q.prm.intersector_gap_length,
        r_q.prm.short_sector_length, r_q.prm.id_head,
        5'h00, r_q.prm.head_select, r_q.prm.drive_select_bits};
      ADDR_CONFIG: rd_mux = {r_q.precomp_start_track, r_q.lock,
        r_q.implied_seek_enable, r_q.fifo_disable_low,
        r_q.polling_disable, r_q.fifo_threshold, r_q.head_load_delay,
        r_q.perp_flags[0], r_q.head_unload_delay, r_q.perp_flags[1], r_q.perp_gap,
        r_q.mfm, r_q.multi_track_flag};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_comb begin
    r_d = r_q;
    // Read data and error captured in setup so both come from flops
    if (setup) begin
      r_d.prdata = mapped ? rd_mux : 32'h0000_0000;
      r_d.pslverr = !mapped;
    end
    // Head timer, one tick per time unit
    if (r_q.dly_cnt != 8'h00) begin
      if (r_q.unit_cnt == HEAD_UNIT_CYC - 6'h01) begin
        r_d.unit_cnt = 6'h00;
        r_d.dly_cnt = r_q.dly_cnt - 8'h01;
      end else begin
        r_d.unit_cnt = r_q.unit_cnt + 6'h01;
      end
    end else if (r_q.loading) begin
      r_d.loading = 1'b0;
    end else if (r_q.unloading) begin
      r_d.unloading = 1'b0;
      r_d.head_loaded = 1'b0;
    end
    case (r_q.phase)
      ST_CMD: begin
        if (acc_wr && apb_req.paddr == ADDR_CMD_DATA) begin
          r_d.opcode = wb;
          r_d.byte_idx = 4'h0;
          r_d.need = first_need;
          if (!first_valid) begin
            r_d.int_pending = 1'b1;
            r_d.int_invalid = 1'b1;
          end else if (op_lo == OP_SENSE_INT) begin
            r_d.phase = ST_RESULT;
            r_d.res_idx = 1'b0;
          end else if (op_lo == OP_LOCK) begin
            r_d.lock = wb[LOCK_BIT];
          end else begin
            r_d.phase = ST_PARAM;
            if (op_lo == OP_SEEK) begin
              r_d.rel_seek = wb[REL_BIT];
              r_d.step_dir = wb[DIR_BIT];
            end else if (first_need == NP_XFER) begin
              r_d.multi_track_flag = wb[MT_BIT];
              r_d.mfm = wb[MFM_BIT];
              r_d.count_enable = 1'b0;
            end
          end
        end
      end
      ST_PARAM: begin
        if (acc_wr && apb_req.paddr == ADDR_CMD_DATA) begin
          r_d.byte_idx = r_q.byte_idx + 4'h1;
          if (is_xfer || is_seek) begin
            case (r_q.byte_idx)
              4'h0: begin
                r_d.prm.drive_select_bits = wb[1:0];
                r_d.prm.head_select = wb[HEAD_BIT];
                if (r_q.opcode[4:0] == OP_VERIFY) begin
                  r_d.count_enable = wb[EC_BIT];
                end
              end
              4'h1: r_d.prm.cylinder = wb;
              4'h2: r_d.prm.id_head = wb;
              4'h3: r_d.prm.sector = wb;
              4'h4: r_d.prm.size_code = wb[2:0];
              4'h5: r_d.prm.last_sector_number = wb;
              4'h6: r_d.prm.intersector_gap_length = wb;
              default: begin
                r_d.prm.short_sector_length = wb;
                if (r_q.count_enable) begin
                  r_d.prm.sectors_per_track = wb;
                end
              end
            endcase
          end else if (r_q.opcode[4:0] == OP_SPECIFY) begin
            if (r_q.byte_idx == 4'h0) begin
              r_d.head_unload_delay = wb[3:0];
            end else begin
              r_d.head_load_delay = wb[7:1];
            end
          end else if (r_q.opcode[4:0] == OP_CONFIGURE) begin
            if (r_q.byte_idx == 4'h1) begin
              r_d.implied_seek_enable = wb[EIS_BIT];
              r_d.fifo_disable_low = wb[FIFO_DISABLE_LOW_BIT];
              r_d.polling_disable = wb[POLL_BIT];
              r_d.fifo_threshold = wb[3:0];
            end else if (r_q.byte_idx == 4'h2) begin
              r_d.precomp_start_track = wb;
            end
          end else if (wb[OW_BIT]) begin
            // Flags change only with the overwrite bit set
            r_d.perp_flags = wb[PERP_D0_BIT+1:PERP_D0_BIT];
            r_d.perp_gap = wb[PERP_GAP_BIT];
          end
          if (r_q.byte_idx + 4'h1 == r_q.need) begin
            r_d.phase = (is_xfer || is_seek) ? ST_EXEC : ST_CMD;
            r_d.byte_pos = 16'h0000;
            if (is_xfer) begin
              r_d.unloading = 1'b0;
              if (!r_q.head_loaded || r_q.loading) begin
                r_d.head_loaded = 1'b1;
                r_d.loading = 1'b1;
                r_d.dly_cnt = {1'b0, r_q.head_load_delay};
                r_d.unit_cnt = 6'h00;
              end else begin
                r_d.dly_cnt = 8'h00;
              end
            end
          end
        end
      end
      ST_EXEC: begin
        if (is_xfer && head_ready && disk_byte) begin
          if (r_q.byte_pos == phys_len - 16'h0001) begin
            r_d.byte_pos = 16'h0000;
            if (r_q.prm.sector == r_q.prm.last_sector_number) begin
              if (r_q.multi_track_flag && !r_q.prm.head_select) begin
                r_d.prm.head_select = 1'b1;
                r_d.prm.id_head = 8'h01;
                r_d.prm.sector = FIRST_SECTOR;
              end else begin
                r_d.phase = ST_CMD;
              end
            end else begin
              r_d.prm.sector = r_q.prm.sector + 8'h01;
            end
          end else begin
            r_d.byte_pos = r_q.byte_pos + 16'h0001;
          end
        end
        if (exec_done) begin
          r_d.phase = ST_CMD;
        end
        if (is_seek && exec_done) begin
          r_d.int_pending = 1'b1;
          r_d.int_invalid = 1'b0;
        end
        if (is_xfer && r_d.phase == ST_CMD) begin
          r_d.unloading = 1'b1;
          r_d.loading = 1'b0;
          r_d.dly_cnt = {4'h0, r_q.head_unload_delay};
          r_d.unit_cnt = 6'h00;
        end
      end
      ST_RESULT: begin
        if (acc_rd && apb_req.paddr == ADDR_CMD_DATA) begin
          r_d.res_idx = 1'b1;
          if (r_q.res_idx) begin
            r_d.phase = ST_CMD;
            r_d.int_pending = 1'b0;
            r_d.int_invalid = 1'b0;
          end
        end
      end
      default: r_d.phase = ST_CMD;
    endcase
    // Soft reset clears the core; specify timing always survives
    if (soft_rst) begin
      r_d = REGS_RST;
      r_d.head_load_delay = r_q.head_load_delay;
      r_d.head_unload_delay = r_q.head_unload_delay;
      r_d.lock = r_q.lock;
      r_d.prdata = r_q.prdata;
      r_d.pslverr = r_q.pslverr;
      if (r_q.lock) begin
        r_d.fifo_disable_low = r_q.fifo_disable_low;
        r_d.fifo_threshold = r_q.fifo_threshold;
        r_d.precomp_start_track = r_q.precomp_start_track;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_q <= REGS_RST;
    end else if (ce) begin
      r_q <= r_d;
    end
  end

  // Zero wait states: answer in the first access cycle
  assign apb_rsp.pready = apb_req.psel && apb_req.penable;
  assign apb_rsp.pslverr = r_q.pslverr && apb_req.psel && apb_req.penable;
  assign apb_rsp.prdata = r_q.prdata;

  always_comb begin
    params = r_q.prm;
    // Codes 10 and 11 address no drive
    case (r_q.prm.drive_select_bits)
      2'b00: params.drive_onehot = 2'b01;
      2'b01: params.drive_onehot = 2'b10;
      default: params.drive_onehot = 2'b00;
    endcase
  end

  assign int_req = r_q.int_pending;
  assign head_load = r_q.head_loaded;
  assign head_ready = r_q.phase == ST_EXEC && r_q.head_loaded &&
    !r_q.loading;
  assign host_pass = is_read && head_ready && disk_byte &&
    r_q.byte_pos < host_len;
  assign zero_fill = is_write && head_ready && disk_byte &&
    r_q.byte_pos >= host_len;
  assign crc_byte = is_xfer && head_ready && disk_byte;
  assign implied_seek_req = r_q.phase == ST_EXEC && is_xfer &&
    (is_read || is_write) && r_q.implied_seek_enable;
  assign step_dir = r_q.step_dir;
  assign rel_seek = r_q.rel_seek;
  assign fifo_enabled = !r_q.fifo_disable_low;
  assign fifo_threshold = r_q.fifo_threshold;
  assign precomp_start_track = r_q.precomp_start_track;
  assign mfm_mode = r_q.mfm;
  assign perp_gap2_alter = r_q.perp_gap &&
    r_q.perp_flags[r_q.prm.drive_select_bits[0]];
  assign gap3_length = r_q.prm.intersector_gap_length;
  assign perp_drive_flags = r_q.perp_flags;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic first_wr;
  assign first_wr = ce && !soft_rst && r_q.phase == ST_CMD && acc_wr &&
    apb_req.paddr == ADDR_CMD_DATA;

  invalid_op_int_a: assert property (first_wr && !first_valid |=>
    int_req && r_q.int_invalid && r_q.phase == ST_CMD)
    else $error("invalid opcode did not raise interrupt");
  sense_invalid_a: assert property (r_q.phase == ST_RESULT &&
    r_q.int_invalid && !r_q.res_idx |-> result_byte == ST0_INVALID)
    else $error("sense interrupt did not report invalid command");
  cyl_capture_a: assert property (ce && !soft_rst &&
    r_q.phase == ST_PARAM && is_xfer && r_q.byte_idx == 4'h1 && acc_wr &&
    apb_req.paddr == ADDR_CMD_DATA |=> params.cylinder == $past(wb))
    else $error("cylinder byte not captured");
  perp_flag_a: assert property (ce && !soft_rst &&
    r_q.phase == ST_PARAM && r_q.opcode[4:0] == OP_PERP && acc_wr &&
    apb_req.paddr == ADDR_CMD_DATA && wb[OW_BIT] |=>
    perp_drive_flags == $past(wb[PERP_D0_BIT+1:PERP_D0_BIT]))
    else $error("perpendicular flags not taken");
  seek_dir_a: assert property (first_wr && op_lo == OP_SEEK |=>
    step_dir == $past(wb[DIR_BIT]) ##1 step_dir == $past(step_dir))
    else $error("step direction wrong");
  short_len_a: assert property (r_q.prm.size_code == 3'h0 &&
    !r_q.count_enable |-> host_len == {8'h00, r_q.prm.short_sector_length})
    else $error("short sector length not applied");
  fill_zero_a: assert property (is_write && crc_byte &&
    r_q.byte_pos >= host_len |-> zero_fill && !host_pass)
    else $error("write remainder not zero filled");
  fifo_lock_a: assert property (ce && soft_rst && !r_q.lock |=>
    r_q.fifo_disable_low && fifo_threshold == FIFO_THRESHOLD_RST)
    else $error("soft reset did not restore fifo defaults");
  mt_wrap_a: assert property (ce && !soft_rst && !exec_done &&
    crc_byte && r_q.multi_track_flag && !r_q.prm.head_select &&
    r_q.prm.sector == r_q.prm.last_sector_number &&
    r_q.byte_pos == phys_len - 16'h0001 |=>
    params.head_select && params.sector == FIRST_SECTOR &&
    r_q.phase == ST_EXEC)
    else $error("multi-track did not continue on head 1");

  invalid_seen_c: cover property (first_wr && !first_valid ##[1:50]
    r_q.phase == ST_RESULT && r_q.int_invalid);
  mt_used_c: cover property (r_q.multi_track_flag && params.head_select &&
    crc_byte);
  lock_hold_c: cover property (ce && soft_rst && r_q.lock &&
    !r_q.fifo_disable_low);
endmodule
`default_nettype wire

// ==== dv/fcpd_host.sv ====
// Host model: APB master writing command bytes
`timescale 1ns/1ps
`default_nettype none
module fcpd_host
  import fcpd_pkg::*;
(
  input wire logic pclk,
  output fcpd_apb_req_type req,
  input wire fcpd_apb_rsp_type rsp
);
  initial req = '0;
  // Request held until pready is seen at an edge
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic e);
    @(posedge pclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge pclk);
    req.penable <= 1'b1;
    do @(posedge pclk); while (rsp.pready !== 1'b1);
    q = rsp.prdata;
    e = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask
  // Writes one byte to the command register; called for command and parameter bytes alike
  task automatic wb(input logic [7:0] b);
    logic [31:0] q;
    logic e;
    xfer(1'b1, ADDR_CMD_DATA, {24'h0, b}, q, e);
  endtask
endmodule
`default_nettype wire

// ==== dv/test_fcpd_decoder.sv ====
// Testbench for the command decoder
`timescale 1ns/1ps
`default_nettype none
module test_fcpd_decoder
  import fcpd_pkg::*;
;
  logic pclk = 0, presetn = 0, ce = 1, sr_dor = 0, sr_dsr = 0;
  logic disk_byte = 0, exec_done = 0;
  fcpd_apb_req_type req;
  fcpd_apb_rsp_type rsp;
  fcpd_params_type prm;
  logic int_req, hl, hr, hp, zf, crc, isk, sdir, rel, fen, mfm, g2;
  logic [3:0] thr;
  logic [7:0] pre, g3;
  logic [1:0] pdf;
  logic [31:0] q;
  logic e;
  int mismatches = 0, num_checks = 0, p, z, c;
  always #10 pclk = ~pclk;
  fcpd_host host_u (.pclk(pclk), .req(req), .rsp(rsp));
  fcpd_decoder dut_u (.pclk(pclk), .presetn(presetn), .ce(ce),
    .apb_req(req), .apb_rsp(rsp), .soft_reset_dor(sr_dor),
    .soft_reset_dsr(sr_dsr), .disk_byte(disk_byte),
    .exec_done(exec_done), .params(prm), .int_req(int_req),
    .head_load(hl), .head_ready(hr), .host_pass(hp), .zero_fill(zf),
    .crc_byte(crc), .implied_seek_req(isk), .step_dir(sdir),
    .rel_seek(rel), .fifo_enabled(fen), .fifo_threshold(thr),
    .precomp_start_track(pre), .mfm_mode(mfm), .perp_gap2_alter(g2),
    .gap3_length(g3), .perp_drive_flags(pdf));
  task chk(input string n, input logic [31:0] s, input logic [31:0] x);
    num_checks++;
    if (s !== x) begin
      mismatches++;
      $display("ERROR %s exp %h got %h", n, x, s);
    end
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task send(input logic [7:0] b[$]);
    foreach (b[i]) host_u.wb(b[i]);
    repeat (2) @(posedge pclk);
  endtask
  task rd(input logic [7:0] a);
    host_u.xfer(1'b0, a, 32'h0, q, e);
  endtask
  task wready;
    int i;
    i = 0;
    while (hr !== 1'b1 && i < 80) begin
      @(posedge pclk);
      i++;
    end
    chk("head_ready", hr, 1);
  endtask
  // Disk bytes spaced two cycles; outputs sampled with the pulse
  task pump(input int n);
    p = 0; z = 0; c = 0;
    repeat (n) begin
      @(posedge pclk);
      disk_byte <= 1'b1;
      @(posedge pclk);
      p += int'(hp === 1'b1);
      z += int'(zf === 1'b1);
      c += int'(crc === 1'b1);
      disk_byte <= 1'b0;
    end
    @(posedge pclk);
  endtask
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("fifo_en", fen, 0);
    send('{8'h1F});
    chk("int", int_req, 1);
    send('{8'h08});
    rd(ADDR_CMD_DATA);
    chk("st0", q[7:0], ST0_INVALID);
    rd(ADDR_CMD_DATA);
    rd(8'h14);
    chk("slverr", e, 1);
    send('{8'h13, 8'h00, 8'h45, 8'h33});
    chk("fifo_en", fen, 1);
    chk("thr", thr, 5);
    chk("precomp_start_track", pre, 8'h33);
    send('{8'h12, 8'h86});
    chk("perp", pdf, 2'b01);
    chk("gap2", g2, 1);
    send('{8'hC6, 8'h01, 8'hFF, 8'h00, 8'h01, 8'h00, 8'h01, 8'h1B, 8'h04});
    chk("int_clr", int_req, 0);
    chk("cyl", prm.cylinder, 8'hFF);
    chk("drive", prm.drive_onehot, 2'b10);
    chk("mfm", mfm, 1);
    chk("gap3", g3, 8'h1B);
    chk("iseek", isk, 1);
    repeat (40) @(posedge pclk);
    chk("early", hr, 0);
    wready;
    pump(128);
    chk("pass", p, 4);
    chk("crc", c, 128);
    chk("head", prm.head_select, 1);
    chk("sect", prm.sector, 1);
    pump(128);
    chk("pass2", p, 4);
    repeat (40) @(posedge pclk);
    chk("held", hl, 1);
    repeat (20) @(posedge pclk);
    chk("unload", hl, 0);
    send('{8'h05, 8'h00, 8'h05, 8'h00, 8'h01, 8'h00, 8'h01, 8'h1B, 8'h04});
    chk("fm", mfm, 0);
    wready;
    pump(128);
    chk("fill", z, 124);
    for (int d = 0; d < 2; d++) begin
      send('{8'h8F | 8'(d << 6), 8'h00, 8'h10});
      chk("dir", sdir, d);
      chk("rel", rel, 1);
      @(posedge pclk) exec_done <= 1'b1;
      @(posedge pclk) exec_done <= 1'b0;
      send('{8'h08});
      rd(ADDR_CMD_DATA);
      chk("st0s", q[7:0], ST0_SEEK_END);
      rd(ADDR_CMD_DATA);
    end
    send('{8'h94});
    @(posedge pclk) sr_dor <= 1'b1;
    @(posedge pclk) sr_dor <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("lock_fifo", fen, 1);
    chk("lock_thr", thr, 5);
    send('{8'h14});
    @(posedge pclk) sr_dsr <= 1'b1;
    @(posedge pclk) sr_dsr <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("rst_fifo", fen, 0);
    chk("rst_thr", thr, 0);
    // Frozen core must drop a command byte
    ce <= 1'b0;
    send('{8'h1F});
    chk("ce_hold", int_req, 0);
    ce <= 1'b1;
    send('{8'h06, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h1B, 8'hFF});
    chk("n1_busy", hl, 1);
    wready;
    pump(256);
    chk("full_pass", p, 256);
    chk("full_crc", c, 256);
    test_done;
  end
  // Tests take about 1700 cycles
  initial begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    test_done;
  end
endmodule
`default_nettype wire
